// ### src/dbgbk_pkg.sv
// Package of constants and carriers for the debug breakpoint control block.
package dbgbk_pkg;
  // ==========================================================================
  // Register offsets on the debug port write address space.
  localparam logic [7:0] DBGBK_OFS_MATCH0 = 8'h00;
  localparam logic [7:0] DBGBK_OFS_MATCH1 = 8'h04;
  localparam logic [7:0] DBGBK_OFS_MATCH2 = 8'h08;
  localparam logic [7:0] DBGBK_OFS_MATCH3 = 8'h0c;
  localparam logic [7:0] DBGBK_OFS_BRK_CTL = 8'h10;
  localparam logic [7:0] DBGBK_OFS_MASTER_CTL = 8'h11;
  // ==========================================================================
  // Field positions and reset values.
  localparam int DBGBK_BIT_NEXT = 7;
  localparam int DBGBK_BIT_EN0 = 3;
  localparam int DBGBK_BIT_IGN1 = 2;
  localparam int DBGBK_BIT_IGN0 = 1;
  localparam int DBGBK_BIT_STEP = 0;
  localparam int DBGBK_BIT_RESET = 7;
  localparam int DBGBK_BIT_WAKE = 6;
  localparam logic [7:0] DBGBK_BRK_CTL_RST = 8'h00;
  localparam logic [7:0] DBGBK_MASTER_CTL_RST = 8'h00;
  // ==========================================================================
  // Timing of the CPU reset pulse.
  localparam int DBGBK_CPU_RESET_NS = 1000;
  localparam int DBGBK_CLK_NS = 50;
  localparam int DBGBK_CPU_RESET_CYC = (DBGBK_CPU_RESET_NS + DBGBK_CLK_NS - 1) / DBGBK_CLK_NS;
  // ==========================================================================
  // Register write from the link domain.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dbgbk_wr_t;
  // CPU fetch status.
  typedef struct packed {
    logic fetch;
    logic first_opcode;
    logic instr_end;
    logic long_mode;
    logic [7:0] base_page;
    logic [23:0] addr;
  } dbgbk_cpu_t;
endpackage

// ### src/dbgbk_top.sv
// Debug breakpoint control: comparators, break flag, single step, master control.
// Contract
// - Writing 0 to next-break bit disables it and releases a held break.
// - Next-break bit at 1 halts the CPU on the next instruction.
// - Breaks only at first opcode of an instruction or at instruction end, never inside one.
// - Clock pin high, data pin low at reset end sets next-break bit.
// - An enabled comparator match taking a break sets next-break bit.
// - Host write of 1 to next-break bit forces a break.
// - Bits 6..3 enable comparators 3..0; zero disables each.
// - Comparator 1, ignore-low clear: full 24-bit equality required.
// - Comparator 1, ignore-low set: bits 23..8 only, 256-byte page.
// - Comparator 0, ignore-low clear: full 24-bit equality required.
// - Comparator 0, ignore-low set: bits 23..8 only, 256-byte page.
// - Single-step bit at 1 halts after every instruction.
// - Break control at write address 10h, write-only, resets to zero.
// - Master control lets the host reset the CPU and wake it.
// - Long mode uses full address; else base page with 16-bit address.
// - Match on a non-first fetch defers break to instruction end.
// - Master bit 7 starts CPU reset and clears when reset ends.
`timescale 1ns/1ns
`default_nettype none
module dbgbk_top
  import dbgbk_pkg::*;
#(
  parameter int RESET_CYC = DBGBK_CPU_RESET_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic link_wr_valid,
  input wire dbgbk_wr_t link_wr,
  input wire logic debug_clock_pin,
  input wire logic debug_data_pin,
  input wire dbgbk_cpu_t cpu,
  output logic cpu_halt,
  output logic cpu_reset_out,
  output logic cpu_wake
);
  // ==========================================================================
  // Link domain: capture the write word and toggle an event.
  dbgbk_wr_t lw_reg, lw_next;
  logic ltog_reg, ltog_next;
  always_comb begin
    lw_next = lw_reg;
    ltog_next = ltog_reg;
    if (link_wr_valid) begin
      lw_next = link_wr;
      ltog_next = ~ltog_reg;
    end
  end
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lw_reg <= '0;
      ltog_reg <= 1'b0;
    end else begin
      lw_reg <= lw_next;
      ltog_reg <= ltog_next;
    end
  end

  // ==========================================================================
  // System domain: synchronisers for the toggle, the word and the pins.
  logic [2:0] tsync_reg, tsync_next;
  logic [1:0] ck_sync_reg, ck_sync_next, da_sync_reg, da_sync_next;
  dbgbk_wr_t wr_hold_reg, wr_hold_next;
  logic stb_reg, stb_next;
  logic wr_stb;
  always_comb begin
    tsync_next = {tsync_reg[1:0], ltog_reg};
    // The strobe waits one cycle so that it meets the word already held.
    stb_next = (tsync_reg[2] != tsync_reg[1]);
    ck_sync_next = {ck_sync_reg[0], debug_clock_pin};
    da_sync_next = {da_sync_reg[0], debug_data_pin};
    wr_hold_next = wr_hold_reg;
    // The word is stable for many link cycles before the toggle settles.
    if (tsync_reg[1] != tsync_reg[2]) begin
      wr_hold_next = lw_reg;
    end
  end
  assign wr_stb = stb_reg;

  // ==========================================================================
  // Comparators and register state.
  logic [23:0] match_reg [4];
  logic [23:0] match_next [4];
  logic [7:0] ctl_reg, ctl_next;
  logic rst_active_reg, rst_active_next;
  logic [15:0] rst_cnt_reg, rst_cnt_next;
  logic wake_reg, wake_next;
  logic strap_reg, strap_next;
  logic pend_reg, pend_next;
  logic halt_reg, halt_next;
  logic [23:0] cmp_addr;
  logic [3:0] hit;
  logic any_hit;
  logic boundary;
  logic [7:0] wa;
  logic [7:0] wd;

  function automatic logic cmp_hit(input logic [23:0] a, input logic [23:0] m, input logic ign);
    cmp_hit = (a[23:8] == m[23:8]) && (ign || (a[7:0] == m[7:0]));
  endfunction

  assign wa = wr_hold_reg.addr;
  assign wd = wr_hold_reg.data;
  assign cmp_addr = cpu.long_mode ? cpu.addr : {cpu.base_page, cpu.addr[15:0]};
  assign hit[0] = ctl_reg[DBGBK_BIT_EN0] && cmp_hit(cmp_addr, match_reg[0], ctl_reg[DBGBK_BIT_IGN0]);
  assign hit[1] = ctl_reg[DBGBK_BIT_EN0 + 1] && cmp_hit(cmp_addr, match_reg[1], ctl_reg[DBGBK_BIT_IGN1]);
  assign hit[2] = ctl_reg[DBGBK_BIT_EN0 + 2] && cmp_hit(cmp_addr, match_reg[2], 1'b0);
  assign hit[3] = ctl_reg[DBGBK_BIT_EN0 + 3] && cmp_hit(cmp_addr, match_reg[3], 1'b0);
  assign any_hit = cpu.fetch && (|hit);
  assign boundary = cpu.instr_end;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match_next[i] = match_reg[i];
    end
    ctl_next = ctl_reg;
    rst_active_next = rst_active_reg;
    rst_cnt_next = rst_cnt_reg;
    wake_next = 1'b0;
    strap_next = 1'b0;
    pend_next = pend_reg;
    halt_next = halt_reg;
    if (wr_stb) begin
      for (int i = 0; i < 4; i++) begin
        for (int b = 0; b < 3; b++) begin
          if (wa == DBGBK_OFS_MATCH0 + 8'(4 * i + b)) begin
            match_next[i][8 * b +: 8] = wd;
          end
        end
      end
      if (wa == DBGBK_OFS_BRK_CTL) begin
        ctl_next = wd;
        if (!wd[DBGBK_BIT_NEXT]) begin
          halt_next = 1'b0;
          pend_next = 1'b0;
        end
      end
      if (wa == DBGBK_OFS_MASTER_CTL) begin
        if (wd[DBGBK_BIT_RESET]) begin
          rst_active_next = 1'b1;
          rst_cnt_next = 16'(RESET_CYC);
        end
        wake_next = wd[DBGBK_BIT_WAKE];
      end
    end
    if (rst_active_reg) begin
      if (rst_cnt_reg <= 16'h0001) begin
        rst_active_next = 1'b0;
        strap_next = 1'b1;
      end
      rst_cnt_next = rst_cnt_reg - 16'h0001;
    end
    if (strap_reg && ck_sync_reg[1] && !da_sync_reg[1]) begin
      ctl_next[DBGBK_BIT_NEXT] = 1'b1;
    end
    if (any_hit && !halt_reg) begin
      pend_next = 1'b1;
    end
    if (!halt_reg && !rst_active_reg) begin
      if (cpu.fetch && cpu.first_opcode && (ctl_next[DBGBK_BIT_NEXT] || any_hit)) begin
        halt_next = 1'b1;
        ctl_next[DBGBK_BIT_NEXT] = 1'b1;
        pend_next = 1'b0;
      end else if (boundary && (pend_reg || any_hit || ctl_reg[DBGBK_BIT_STEP])) begin
        halt_next = 1'b1;
        ctl_next[DBGBK_BIT_NEXT] = 1'b1;
        pend_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        match_reg[i] <= '0;
      end
      tsync_reg <= '0;
      stb_reg <= 1'b0;
      // The pin synchronisers keep sampling so the strap sees real levels at release.
      ck_sync_reg <= ck_sync_next;
      da_sync_reg <= da_sync_next;
      wr_hold_reg <= '0;
      ctl_reg <= DBGBK_BRK_CTL_RST;
      rst_active_reg <= 1'b0;
      rst_cnt_reg <= '0;
      wake_reg <= 1'b0;
      strap_reg <= 1'b1;
      pend_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        match_reg[i] <= match_next[i];
      end
      tsync_reg <= tsync_next;
      stb_reg <= stb_next;
      ck_sync_reg <= ck_sync_next;
      da_sync_reg <= da_sync_next;
      wr_hold_reg <= wr_hold_next;
      ctl_reg <= ctl_next;
      rst_active_reg <= rst_active_next;
      rst_cnt_reg <= rst_cnt_next;
      wake_reg <= wake_next;
      strap_reg <= strap_next;
      pend_reg <= pend_next;
      halt_reg <= halt_next;
    end
  end

  assign cpu_halt = halt_reg;
  assign cpu_reset_out = rst_active_reg;
  assign cpu_wake = wake_reg;

  // ==========================================================================
  // Assertions.
  a_release_on_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_stb && wa == DBGBK_OFS_BRK_CTL && !wd[DBGBK_BIT_NEXT]) |=> !cpu_halt)
    else $error("Halt not released after clearing next-break bit.");

  a_next_halts: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctl_reg[DBGBK_BIT_NEXT] && cpu.fetch && cpu.first_opcode && !halt_reg && !rst_active_reg && !wr_stb)
    |=> cpu_halt)
    else $error("Next-break bit did not halt the CPU.");

  a_halt_boundary: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(cpu_halt) |-> $past(cpu.first_opcode && cpu.fetch) || $past(cpu.instr_end))
    else $error("Halt taken off an instruction boundary.");

  a_hit_sets_next: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(cpu_halt) |-> ctl_reg[DBGBK_BIT_NEXT])
    else $error("Break taken without next-break bit set.");

  a_step_halts: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctl_reg[DBGBK_BIT_STEP] && cpu.instr_end && !halt_reg && !rst_active_reg && !wr_stb) |=> cpu_halt)
    else $error("Single step did not halt at instruction end.");

  a_ctl_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_stb && wa == DBGBK_OFS_BRK_CTL && !cpu.fetch && !cpu.instr_end && !strap_reg)
    |=> ctl_reg == $past(wd))
    else $error("Break control write not stored.");

  a_reset_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_stb && wa == DBGBK_OFS_MASTER_CTL && wd[DBGBK_BIT_RESET]) |=> cpu_reset_out)
    else $error("CPU reset not started.");

  a_reset_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(cpu_reset_out) |-> strap_reg)
    else $error("Strap sample not taken at reset end.");

  a_hit_or: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hit[0] && cpu.fetch && cpu.first_opcode && !halt_reg && !rst_active_reg) |=> cpu_halt)
    else $error("Comparator match did not break.");

  a_base_page: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cpu.long_mode |-> cmp_addr[23:16] == cpu.base_page)
    else $error("Short mode address not built from base page.");

  a_long_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu.long_mode |-> cmp_addr == cpu.addr)
    else $error("Long mode address not taken whole.");

  a_wake_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_stb && wa == DBGBK_OFS_MASTER_CTL && wd[DBGBK_BIT_WAKE]) |=> cpu_wake)
    else $error("Wake not raised after master write.");

  a_wake_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cpu_wake && !wr_stb) |=> !cpu_wake)
    else $error("Wake held longer than one cycle.");

  a_reset_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_reset_out |-> rst_cnt_reg != 16'h0000)
    else $error("Reset active with an empty counter.");

  a_no_break_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rst_active_reg && !halt_reg) |=> !cpu_halt)
    else $error("Break taken during CPU reset.");

  a_enable_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctl_reg[DBGBK_BIT_EN0] |-> !hit[0])
    else $error("Disabled comparator reported a match.");

  a_mid_defers: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (any_hit && !cpu.first_opcode && !cpu.instr_end && !halt_reg && !ctl_reg[DBGBK_BIT_NEXT] && !wr_stb && !strap_reg)
    |=> !cpu_halt && pend_reg)
    else $error("Match inside an instruction not deferred.");

  a_pend_at_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pend_reg && cpu.instr_end && !halt_reg && !rst_active_reg && !wr_stb) |=> cpu_halt)
    else $error("Deferred break not taken at instruction end.");

  a_halt_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cpu_halt && !(wr_stb && wa == DBGBK_OFS_BRK_CTL && !wd[DBGBK_BIT_NEXT])) |=> cpu_halt)
    else $error("Halt released without a clear.");

  a_strap_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (strap_reg && ck_sync_reg[1] && !da_sync_reg[1]) |=> ctl_reg[DBGBK_BIT_NEXT])
    else $error("Strap did not set next-break bit.");

  a_full_match1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hit[1] && !ctl_reg[DBGBK_BIT_IGN1]) |-> cmp_addr == match_reg[1])
    else $error("Comparator 1 matched without full equality.");

  a_page_match1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctl_reg[DBGBK_BIT_EN0 + 1] && ctl_reg[DBGBK_BIT_IGN1] && cmp_addr[23:8] == match_reg[1][23:8]) |-> hit[1])
    else $error("Comparator 1 missed a page match.");

  a_full_match0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hit[0] && !ctl_reg[DBGBK_BIT_IGN0]) |-> cmp_addr == match_reg[0])
    else $error("Comparator 0 matched without full equality.");

  a_page_match0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctl_reg[DBGBK_BIT_EN0] && ctl_reg[DBGBK_BIT_IGN0] && cmp_addr[23:8] == match_reg[0][23:8]) |-> hit[0])
    else $error("Comparator 0 missed a page match.");
endmodule // dbgbk_top
`default_nettype wire

// ### dv/dbgbk_host.sv
// Model of the debug host on the serial link.
`timescale 1ns/1ns
`default_nettype none
module dbgbk_host
  import dbgbk_pkg::*;
(
  input wire logic link_clk,
  output logic link_wr_valid,
  output dbgbk_wr_t link_wr,
  output logic debug_clock_pin,
  output logic debug_data_pin
);
  // ==========
  // Register writes, spaced for the crossing; after a write the idle bus shows inverted data.
  initial begin
    link_wr_valid = 1'b0;
    link_wr = '0;
    debug_clock_pin = 1'b0;
    debug_data_pin = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge link_clk);
    link_wr_valid <= 1'b1;
    link_wr <= {a, d};
    @(posedge link_clk);
    link_wr_valid <= 1'b0;
    link_wr <= ~{a, d};
    repeat (12) @(posedge link_clk);
  endtask
  // Pin levels that the device samples at the end of a reset.
  task automatic strap(input logic c, input logic d);
    debug_clock_pin <= c;
    debug_data_pin <= d;
  endtask
  // Clearing the next-break bit lets the halted CPU run on.
  task automatic resume();
    wr(DBGBK_OFS_BRK_CTL, 8'h00);
  endtask
endmodule // dbgbk_host
`default_nettype wire

// ### dv/tb_dbgbk_top.sv
// Self-checking bench of the debug breakpoint control.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_dbgbk_top
  import dbgbk_pkg::*;
;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic link_rst = 1'b1;
  logic link_wr_valid;
  dbgbk_wr_t link_wr;
  logic debug_clock_pin;
  logic debug_data_pin;
  dbgbk_cpu_t cpu = '0;
  logic cpu_halt;
  logic cpu_reset_out;
  logic cpu_wake;
  int n_fail = 0;
  int compares = 0;
  logic [23:0] m [4] = '{24'h123456, 24'habcd12, 24'h0f0e0d, 24'h778899};
  // Rows: control, long mode, base page, address, expected halt.
  logic [41:0] rows [14] = '{
    {8'h08, 1'b1, 8'h00, 24'h123456, 1'b1}, {8'h08, 1'b1, 8'h00, 24'h123457, 1'b0},
    {8'h0a, 1'b1, 8'h00, 24'h1234ff, 1'b1}, {8'h00, 1'b1, 8'h00, 24'h123456, 1'b0},
    {8'h10, 1'b1, 8'h00, 24'habcd12, 1'b1}, {8'h10, 1'b1, 8'h00, 24'habcd13, 1'b0},
    {8'h14, 1'b1, 8'h00, 24'habcd00, 1'b1}, {8'h20, 1'b1, 8'h00, 24'h0f0e0d, 1'b1},
    {8'h40, 1'b1, 8'h00, 24'h778899, 1'b1}, {8'h78, 1'b1, 8'h00, 24'h778899, 1'b1},
    {8'h08, 1'b0, 8'h12, 24'h003456, 1'b1}, {8'h08, 1'b0, 8'h00, 24'h123456, 1'b0},
    {8'h80, 1'b1, 8'h00, 24'h000000, 1'b1}, {8'h06, 1'b1, 8'h00, 24'h123456, 1'b0}};
  // ==========
  // Clocks and instances.
  initial forever #25 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  dbgbk_top #(.RESET_CYC(4)) i_dbgbk_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .link_clk(link_clk),
    .link_rst(link_rst), .link_wr_valid(link_wr_valid), .link_wr(link_wr), .debug_clock_pin(debug_clock_pin),
    .debug_data_pin(debug_data_pin), .cpu(cpu), .cpu_halt(cpu_halt), .cpu_reset_out(cpu_reset_out),
    .cpu_wake(cpu_wake));
  dbgbk_host i_dbgbk_host (.link_clk(link_clk), .link_wr_valid(link_wr_valid), .link_wr(link_wr),
    .debug_clock_pin(debug_clock_pin), .debug_data_pin(debug_data_pin));
  // ==========
  // Tasks.
  task automatic run(input logic [35:0] c);
    @(posedge clk_sys);
    cpu <= c;
    @(posedge clk_sys);
    cpu <= '0;
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #3000000;
    n_fail++;
    tally_and_finish();
  end
  // ==========
  // Main sequence.
  initial begin
    logic [41:0] r;
    int k;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge link_clk);
    link_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("halt at reset", 1'b0, cpu_halt)
    run({3'b110, 1'b1, 32'h0});
    `CHK("fetch after reset", 1'b0, cpu_halt)
    $display("end reset");
    for (int i = 0; i < 12; i++) i_dbgbk_host.wr(8'(4 * (i / 3) + i % 3), m[i / 3][8 * (i % 3) +: 8]);
    foreach (rows[i]) begin
      r = rows[i];
      i_dbgbk_host.wr(DBGBK_OFS_BRK_CTL, r[41:34]);
      run({3'b110, r[33:1]});
      `CHK("row halt", r[0], cpu_halt)
      i_dbgbk_host.resume();
      `CHK("row release", 1'b0, cpu_halt)
    end
    $display("end rows");
    i_dbgbk_host.wr(DBGBK_OFS_BRK_CTL, 8'h08);
    run({3'b100, 1'b1, 8'h00, 24'h123456});
    `CHK("mid fetch", 1'b0, cpu_halt)
    run({3'b001, 33'h0});
    `CHK("deferred", 1'b1, cpu_halt)
    i_dbgbk_host.resume();
    i_dbgbk_host.wr(DBGBK_OFS_BRK_CTL, 8'h01);
    run({3'b001, 33'h0});
    `CHK("step", 1'b1, cpu_halt)
    i_dbgbk_host.resume();
    run({3'b001, 33'h0});
    `CHK("step off", 1'b0, cpu_halt)
    $display("end defer and step");
    i_dbgbk_host.strap(1'b1, 1'b0);
    k = 0;
    fork
      i_dbgbk_host.wr(DBGBK_OFS_MASTER_CTL, 8'h80);
      for (int j = 0; j < 40; j++) begin
        @(posedge clk_sys);
        #1;
        k += int'(cpu_reset_out);
      end
    join
    `CHK("reset cycles", 4, k)
    i_dbgbk_host.strap(1'b0, 1'b1);
    run({3'b110, 1'b1, 32'h0});
    `CHK("strap break", 1'b1, cpu_halt)
    i_dbgbk_host.resume();
    k = 0;
    fork
      i_dbgbk_host.wr(DBGBK_OFS_MASTER_CTL, 8'h40);
      for (int j = 0; j < 40; j++) begin
        @(posedge clk_sys);
        #1;
        k += int'(cpu_wake);
      end
    join
    `CHK("wake pulses", 1, k)
    $display("end master");
    tally_and_finish();
  end
endmodule // tb_dbgbk_top
`default_nettype wire
